// [dv/host_bus_model.sv]
`timescale 1ns/1ns
module host_bus_model (
  input  wire logic clk,
  input  wire logic wake_request_out,
  input  wire logic wake_request_oe,
  output logic      chip_select_low,
  output logic      write_strobe_low,
  output logic      read_strobe_low,
  output logic      wake_level
);
  // The wake line has a board pull-up, so a released open-drain pin reads high.
  assign wake_level = wake_request_oe ? wake_request_out : 1'b1;
  initial begin
    chip_select_low  = 1'b1;
    write_strobe_low = 1'b1;
    read_strobe_low  = 1'b1;
  end
  // one host cycle
  // Wake writes aim at the byte-order test register; this model carries no address.
  task automatic cycle(input logic is_write);
    @(negedge clk);
    chip_select_low  = 1'b0;
    write_strobe_low = ~is_write;
    read_strobe_low  = is_write;
    @(negedge clk);
    chip_select_low  = 1'b1;
    write_strobe_low = 1'b1;
    read_strobe_low  = 1'b1;
    repeat (2) @(negedge clk);
  endtask
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ns
module testbench
  import reset_wake_pkg::*;
;
  logic clk, sys_rst, ext_reset_in_low, ref_osc_in, power_save_req, wake_event;
  logic wake_enable, wake_polarity_high, wake_open_drain, crossover_auto_enable_pin;
  logic speed_select_pin, chip_select_low, write_strobe_low, read_strobe_low, wake_level;
  logic ref_osc_out, core_reset, writes_unlocked, host_write_pulse, power_saving;
  logic wake_request_out, wake_request_oe, crossover_auto, link_speed_100;
  logic link_full_duplex, link_autoneg;
  int          mismatches = 0;
  int          checked    = 0;
  logic        exp_q[$];
  logic [31:0] seed = 32'h295014ad;

  reset_wake_strap_control reset_wake_strap_control_i (.clk(clk), .sys_rst(sys_rst),
    .ext_reset_in_low(ext_reset_in_low), .ref_osc_in(ref_osc_in), .ref_osc_out(ref_osc_out),
    .chip_select_low(chip_select_low), .write_strobe_low(write_strobe_low),
    .read_strobe_low(read_strobe_low), .power_save_req(power_save_req),
    .wake_event(wake_event), .wake_enable(wake_enable),
    .wake_polarity_high(wake_polarity_high), .wake_open_drain(wake_open_drain),
    .crossover_auto_enable_pin(crossover_auto_enable_pin),
    .speed_select_pin(speed_select_pin), .core_reset(core_reset),
    .writes_unlocked(writes_unlocked), .host_write_pulse(host_write_pulse),
    .power_saving(power_saving), .wake_request_out(wake_request_out),
    .wake_request_oe(wake_request_oe), .crossover_auto(crossover_auto),
    .link_speed_100(link_speed_100), .link_full_duplex(link_full_duplex),
    .link_autoneg(link_autoneg));

  host_bus_model host_bus_model_i (.clk(clk), .wake_request_out(wake_request_out),
    .wake_request_oe(wake_request_oe), .chip_select_low(chip_select_low),
    .write_strobe_low(write_strobe_low), .read_strobe_low(read_strobe_low),
    .wake_level(wake_level));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string name, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_reset(input logic use_ext, input logic strap);
    @(negedge clk);
    speed_select_pin = strap;
    if (use_ext) ext_reset_in_low = 1'b0;
    else sys_rst = 1'b1;
    #1;
    check("core_reset", core_reset, 1'b1);
    repeat (10) @(negedge clk);
    check("writes_unlocked", writes_unlocked, 1'b0);
    check("wake_request_oe", wake_request_oe, 1'b0);
    sys_rst = 1'b0;
    ext_reset_in_low = 1'b1;
    @(negedge clk);
    check("core_reset", core_reset, 1'b1);
    repeat (2) @(negedge clk);
    speed_select_pin = ~strap;
    @(negedge clk);
    check("core_reset", core_reset, 1'b0);
    check("link_speed_100", link_speed_100, strap);
    check("link_autoneg", link_autoneg, strap);
    check("link_full_duplex", link_full_duplex, 1'b0);
  endtask

  task automatic host(input logic wr, input logic accept);
    if (accept) exp_q.push_back(1'b1);
    host_bus_model_i.cycle(wr);
  endtask

  task automatic sleep_wake(input logic pol, input logic od);
    wake_polarity_high = pol;
    wake_open_drain = od;
    host(1'b0, 1'b0);
    check("writes_unlocked", writes_unlocked, 1'b1);
    @(negedge clk);
    power_save_req = 1'b1;
    @(negedge clk);
    power_save_req = 1'b0;
    check("power_saving", power_saving, 1'b1);
    for (int e = 0; e < 2; e++) begin
      wake_enable = e[0];
      wake_event = 1'b1;
      @(negedge clk);
      wake_event = 1'b0;
      repeat (2) @(negedge clk);
      check("wake_level", wake_level, e[0] ? pol : ~pol);
    end
    check("power_saving", power_saving, 1'b1);
    host(1'b1, 1'b0);
    check("power_saving", power_saving, 1'b0);
    check("writes_unlocked", writes_unlocked, 1'b0);
    check("wake_level", wake_level, ~pol);
    host(1'b1, 1'b0);
    host(1'b0, 1'b0);
    host(1'b1, 1'b1);
  endtask

  always @(negedge clk) begin
    if (host_write_pulse === 1'b1) begin
      if (exp_q.size() == 0) check("host_write_pulse", 1'b1, 1'b0);
      else check("host_write_pulse", host_write_pulse, exp_q.pop_front());
    end
  end

  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  initial begin
    {sys_rst, ref_osc_in, power_save_req, wake_event, wake_enable} = 5'h10;
    {wake_polarity_high, wake_open_drain, crossover_auto_enable_pin} = 3'h0;
    ext_reset_in_low = 1'b1;
    speed_select_pin = 1'b1;
    do_reset(1'b0, 1'b0);
    host(1'b1, 1'b0);
    for (int i = 0; i < 4; i++) sleep_wake(i[0], i[1]);
    do_reset(1'b1, 1'b1);
    for (int i = 0; i < 16; i++) begin
      seed = xorshift(seed);
      @(negedge clk);
      check("crossover_auto", crossover_auto, crossover_auto_enable_pin);
      check("ref_osc_out", ref_osc_out, ~ref_osc_in);
      crossover_auto_enable_pin = seed[0];
      ref_osc_in = seed[1];
    end
    check("writes drained", exp_q.size() == 0, 1'b1);
    complete_run();
  end
endmodule

// [src/reset_release_sync.sv]
`timescale 1ns/1ns
module reset_release_sync
  import reset_wake_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ext_reset_in_low,
  output logic      rst_core
);

  logic [RST_SYNC_STAGES-1:0] chain_r;
  logic                       rst_any;

  assign rst_any = sys_rst | ~ext_reset_in_low;

  always_ff @(posedge clk or posedge rst_any) begin
    if (rst_any) begin
      chain_r <= '1;
    end else begin
      chain_r <= {chain_r[RST_SYNC_STAGES-2:0], 1'b0};
    end
  end

  assign rst_core = chain_r[RST_SYNC_STAGES-1];

endmodule

// [src/reset_wake_pkg.sv]
package reset_wake_pkg;

  // Two stages give the release edge a full cycle to settle before the core sees it.
  localparam int   RST_SYNC_STAGES   = 2;

  // Values held while reset is applied; the speed strap defaults to its pull-up level.
  localparam logic SPEED_STRAP_RESET = 1'b1;
  localparam logic CROSSOVER_RESET   = 1'b0;
  localparam logic FULL_DUPLEX_DFLT  = 1'b0;
  localparam logic WAKE_PENDING_RST  = 1'b0;
  localparam logic READ_DONE_RESET   = 1'b0;
  localparam logic OSC_OUT_RESET     = 1'b0;

  // Strap value that selects the fast link with autonegotiation on.
  localparam logic STRAP_SPEED_100   = 1'b1;

  typedef enum logic [1:0] {
    ST_STRAP,
    ST_RUN,
    ST_SLEEP
  } power_state_type;

endpackage

// [src/reset_wake_strap_control.sv]
`timescale 1ns/1ns
module reset_wake_strap_control
  import reset_wake_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ext_reset_in_low,
  input  wire logic ref_osc_in,
  output logic      ref_osc_out,
  input  wire logic chip_select_low,
  input  wire logic write_strobe_low,
  input  wire logic read_strobe_low,
  input  wire logic power_save_req,
  input  wire logic wake_event,
  input  wire logic wake_enable,
  input  wire logic wake_polarity_high,
  input  wire logic wake_open_drain,
  input  wire logic crossover_auto_enable_pin,
  input  wire logic speed_select_pin,
  output logic      core_reset,
  output logic      writes_unlocked,
  output logic      host_write_pulse,
  output logic      power_saving,
  output logic      wake_request_out,
  output logic      wake_request_oe,
  output logic      crossover_auto,
  output logic      link_speed_100,
  output logic      link_full_duplex,
  output logic      link_autoneg
);

  logic            rst_core;
  power_state_type state_r;
  power_state_type state_nxt;
  logic            wr_cycle_d_r;
  logic            rd_cycle_d_r;
  logic            read_done_r;
  logic            write_pulse_r;
  logic            wake_pending_r;
  logic            wake_level_r;
  logic            wake_oe_r;
  logic            wake_out_r;
  logic            speed_strap_r;
  logic            crossover_r;
  logic            speed_100_r;
  logic            autoneg_r;
  logic            osc_out_r;
  logic            sleep_r;
  logic            full_duplex_r;
  logic            write_cycle;
  logic            read_cycle;
  logic            write_start;
  logic            read_end;
  logic            wake_exit;

  // internal power-on reset backs up the external pin.
  reset_release_sync u_rst_sync (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .ext_reset_in_low (ext_reset_in_low),
    .rst_core         (rst_core)
  );

  assign write_cycle = ~chip_select_low & ~write_strobe_low;
  assign read_cycle  = ~chip_select_low & ~read_strobe_low;
  assign write_start = write_cycle & ~wr_cycle_d_r;
  assign read_end    = ~read_cycle & rd_cycle_d_r;
  assign wake_exit   = (state_r == ST_SLEEP) & write_cycle;

  // crystal amplifier stage mirrored as a registered inverter.
  always_ff @(posedge clk or posedge rst_core) begin
    if (rst_core) begin
      osc_out_r <= OSC_OUT_RESET;
    end else begin
      osc_out_r <= ~ref_osc_in;
    end
  end

  always_ff @(posedge clk or posedge rst_core) begin
    if (rst_core) begin
      wr_cycle_d_r <= 1'b0;
      rd_cycle_d_r <= 1'b0;
    end else begin
      wr_cycle_d_r <= write_cycle;
      rd_cycle_d_r <= read_cycle;
    end
  end

  // write cycle is the only way out of sleep.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_STRAP: begin
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (power_save_req) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (write_cycle) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_STRAP;
      end
    endcase
  end

  // all state returns to reset values while reset is held.
  always_ff @(posedge clk or posedge rst_core) begin
    if (rst_core) begin
      state_r <= ST_STRAP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // registered sleep flag.
  // The flag is taken from the next state so the output needs no decode after the flop.
  always_ff @(posedge clk or posedge rst_core) begin
    if (rst_core) begin
      sleep_r <= 1'b0;
    end else begin
      sleep_r <= (state_nxt == ST_SLEEP);
    end
  end

  // read unlock, lost again on each wake.
  always_ff @(posedge clk or posedge rst_core) begin
    if (rst_core) begin
      read_done_r <= READ_DONE_RESET;
    end else if (read_end && state_r == ST_RUN) begin
      read_done_r <= 1'b1;
    end else if (wake_exit) begin
      read_done_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst_core) begin
    if (rst_core) begin
      write_pulse_r <= 1'b0;
    end else begin
      write_pulse_r <= write_start & read_done_r & (state_r == ST_RUN);
    end
  end

  // the pending wake flag never touches the power state.
  // Set wins over the clear so an event in the wake cycle is kept.
  always_ff @(posedge clk or posedge rst_core) begin
    if (rst_core) begin
      wake_pending_r <= WAKE_PENDING_RST;
    end else if (wake_event && wake_enable) begin
      wake_pending_r <= 1'b1;
    end else if (wake_exit) begin
      wake_pending_r <= 1'b0;
    end
  end

  // programmable polarity and push-pull or open-drain drive.
  always_ff @(posedge clk or posedge rst_core) begin
    if (rst_core) begin
      wake_level_r <= 1'b0;
      wake_out_r   <= 1'b0;
      wake_oe_r    <= 1'b0;
    end else begin
      wake_level_r <= wake_pending_r;
      if (wake_open_drain) begin
        wake_out_r <= 1'b0;
        wake_oe_r  <= ~(wake_pending_r ? wake_polarity_high : ~wake_polarity_high);
      end else begin
        wake_out_r <= wake_pending_r ? wake_polarity_high : ~wake_polarity_high;
        wake_oe_r  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst_core) begin
    if (rst_core) begin
      crossover_r <= CROSSOVER_RESET;
    end else begin
      crossover_r <= crossover_auto_enable_pin;
    end
  end

  // strap caught in the first cycle after release.
  // link speed and autonegotiation decoded from the pin in that same cycle; full duplex held at its default.
  always_ff @(posedge clk or posedge rst_core) begin
    if (rst_core) begin
      speed_strap_r <= SPEED_STRAP_RESET;
      speed_100_r   <= SPEED_STRAP_RESET;
      autoneg_r     <= SPEED_STRAP_RESET;
      full_duplex_r <= FULL_DUPLEX_DFLT;
    end else if (state_r == ST_STRAP) begin
      speed_strap_r <= speed_select_pin;
      full_duplex_r <= FULL_DUPLEX_DFLT;
      speed_100_r   <= (speed_select_pin == STRAP_SPEED_100);
      autoneg_r     <= (speed_select_pin == STRAP_SPEED_100);
    end
  end

  assign ref_osc_out      = osc_out_r;
  assign core_reset       = rst_core;
  assign writes_unlocked  = read_done_r;
  assign host_write_pulse = write_pulse_r;
  assign power_saving     = sleep_r;
  assign wake_request_out = wake_out_r;
  assign wake_request_oe  = wake_oe_r;
  assign crossover_auto   = crossover_r;
  assign link_speed_100   = speed_100_r;
  assign link_full_duplex = full_duplex_r;
  assign link_autoneg     = autoneg_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst_core);

  ext_reset_core_a: assert property (
    @(posedge clk) disable iff (sys_rst) !ext_reset_in_low |-> ##1 rst_core)
    else $error("external reset did not reset the core");
  sleep_holds_a: assert property (
    state_r == ST_SLEEP && !write_cycle |=> state_r == ST_SLEEP)
    else $error("sleep left without a host write");
  write_wakes_a: assert property (
    state_r == ST_SLEEP && write_cycle |=> state_r == ST_RUN && !read_done_r)
    else $error("host write did not wake and relock");
  write_gate_a: assert property (
    write_pulse_r |-> $past(read_done_r) && $past(state_r == ST_RUN))
    else $error("write accepted before a read");
  read_unlock_a: assert property (
    read_end && state_r == ST_RUN |=> read_done_r [*2])
    else $error("completed read did not unlock writes");
  wake_raise_a: assert property (
    wake_event && wake_enable |=> wake_pending_r ##1 wake_level_r)
    else $error("wake request not raised");
  crossover_pin_a: assert property (
    !$past(rst_core) |-> crossover_r == $past(crossover_auto_enable_pin))
    else $error("crossover enable not following pin");
  strap_held_a: assert property (
    state_r != ST_STRAP && $past(state_r) != ST_STRAP |-> $stable(speed_strap_r))
    else $error("speed strap changed after release");
  link_default_a: assert property (
    state_r != ST_STRAP |-> speed_100_r == speed_strap_r && autoneg_r == speed_strap_r)
    else $error("link defaults disagree with strap");

  sleep_wake_c: cover property (state_r == ST_SLEEP ##[1:20] state_r == ST_RUN);
  write_taken_c: cover property (read_end ##[1:20] write_pulse_r);
  wake_req_c: cover property (wake_event && wake_enable ##2 wake_level_r);
  strap_low_c: cover property (state_r == ST_RUN && !speed_strap_r);

endmodule
